// ===== rtl/pwo_top.sv
// Fast DC output generator: PWM, counted pulse train or counter pass-through, with APB registers
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`include "pwo_defines.svh"

module pwo_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic base_clk_en,
    input wire logic counter_out,
    output logic fast_dc_out_pin,
    output logic irq
);

    logic wr_en;
    logic rd_en;
    pwo_pkg::pwo_pwm_cfg_t pwm_sw_r;
    pwo_pkg::pwo_trn_cfg_t trn_sw_r;
    pwo_pkg::pwo_pwm_cfg_t pwm_act_r;
    pwo_pkg::pwo_trn_cfg_t trn_act_r;
    pwo_pkg::pwo_func_t func_sw_r;
    pwo_pkg::pwo_func_t func_act_r;
    logic quad_sw_r;
    logic run_r;
    logic run_d_r;
    logic run_rise;
    logic go_r;
    logic done_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic [2:0] pre_r;
    logic tick;
    logic [15:0] pwm_cnt_r;
    logic [15:0] trn_cnt_r;
    logic [15:0] pulses_r;
    logic trn_phase_r;
    logic pwm_level_r;
    logic pin_nxt;
    logic train_end;

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign run_rise = run_r & ~run_d_r;

    // Zero-wait APB slave; unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & (paddr > `PWO_ADDR_IRQ_MASK || paddr[1:0] != 2'h0);
        end
    end

    // Software-side configuration words; all but the irq mask steer nothing until run entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_sw_r <= {`PWO_RST_WORD, `PWO_RST_WORD};
            trn_sw_r <= {`PWO_RST_WORD, `PWO_RST_WORD};
            func_sw_r <= pwo_pkg::PWO_FN_NONE;
            quad_sw_r <= 1'b0;
            run_r <= 1'b0;
            irq_mask_r <= 2'h0;
        end else if (wr_en && pready) begin
            case (paddr)
                `PWO_ADDR_PWM_PERIOD: pwm_sw_r.period <= pwdata[15:0];
                `PWO_ADDR_PWM_HIGH: pwm_sw_r.high <= pwdata[15:0];
                `PWO_ADDR_TRN_PERIOD: trn_sw_r.period <= pwdata[15:0];
                `PWO_ADDR_TRN_COUNT: trn_sw_r.count <= pwdata[15:0];
                `PWO_ADDR_CTRL: begin
                    run_r <= pwdata[`PWO_CTRL_RUN_BIT];
                    func_sw_r <= pwo_pkg::pwo_func_t'(pwdata[`PWO_CTRL_FUNC_LSB +: 2]);
                    quad_sw_r <= pwdata[`PWO_CTRL_QUAD_BIT];
                end
                `PWO_ADDR_IRQ_MASK: irq_mask_r <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // Run edge detector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_d_r <= 1'b0;
        end else begin
            run_d_r <= run_r;
        end
    end

    // Active configuration is latched only on stop-to-run; stop leaves it untouched so PWM runs on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_act_r <= pwo_pkg::PWO_FN_NONE;
            pwm_act_r <= {`PWO_RST_WORD, `PWO_RST_WORD};
            trn_act_r <= {`PWO_RST_WORD, `PWO_RST_WORD};
        // Active words persist until the next run entry; keeping them over a power loss is up to the supply domain
        end else if (run_rise) begin
            pwm_act_r <= pwm_sw_r;
            trn_act_r <= trn_sw_r;
            if (quad_sw_r && func_sw_r != pwo_pkg::PWO_FN_COUNTER) begin
                func_act_r <= pwo_pkg::PWO_FN_NONE;
            end else begin
                func_act_r <= func_sw_r;
            end
        end
    end

    // Divide the base-clock enable by eight; restarted on run entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r <= 3'h0;
        end else if (run_rise) begin
            pre_r <= 3'h0;
        end else if (base_clk_en) begin
            pre_r <= pre_r + 3'h1;
        end
    end

    assign tick = base_clk_en & (pre_r == 3'h7);

    // PWM period counter: period is (word+1) ticks, high for (high+1) ticks; a zero high word holds the level high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_cnt_r <= 16'h0000;
            pwm_level_r <= 1'b0;
        end else if (run_rise) begin
            pwm_cnt_r <= 16'h0000;
            pwm_level_r <= 1'b0;
        end else if (func_act_r != pwo_pkg::PWO_FN_PWM || pwm_act_r.period == 16'h0000) begin
            pwm_cnt_r <= 16'h0000;
            pwm_level_r <= 1'b1;
        end else if (tick) begin
            if (pwm_cnt_r == pwm_act_r.period) begin
                pwm_cnt_r <= 16'h0000;
            end else begin
                pwm_cnt_r <= pwm_cnt_r + 16'h0001;
            end
            pwm_level_r <= (pwm_act_r.high == 16'h0000) ||
                (pwm_cnt_r == pwm_act_r.period ? 1'b1 : (pwm_cnt_r + 16'h0001) <= pwm_act_r.high);
        end
    end

    // Pulse train: half-period per phase, counts finished pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trn_cnt_r <= 16'h0000;
            pulses_r <= 16'h0000;
            trn_phase_r <= 1'b0;
            go_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            if (run_rise) begin
                trn_phase_r <= 1'b0;
                pulses_r <= 16'h0000;
                trn_cnt_r <= 16'h0000;
            end else if (train_end) begin
                go_r <= 1'b0;
                done_r <= 1'b1;
                trn_phase_r <= 1'b0;
                pulses_r <= 16'h0000;
            end else if (go_r && func_act_r == pwo_pkg::PWO_FN_TRAIN && trn_act_r.period != 16'h0000) begin
                if (tick) begin
                    if (trn_cnt_r == trn_act_r.period) begin
                        trn_cnt_r <= 16'h0000;
                        trn_phase_r <= ~trn_phase_r;
                        if (trn_phase_r) begin
                            pulses_r <= pulses_r + 16'h0001;
                        end
                    end else begin
                        trn_cnt_r <= trn_cnt_r + 16'h0001;
                    end
                end
            end
            // Software write of go: set clears done, hardware completion above wins over a set in the same cycle
            if (wr_en && pready && paddr == `PWO_ADDR_CTRL && !train_end) begin
                go_r <= pwdata[`PWO_CTRL_GO_BIT];
                if (pwdata[`PWO_CTRL_GO_BIT] && !go_r) begin
                    done_r <= 1'b0;
                    pulses_r <= 16'h0000;
                    trn_cnt_r <= 16'h0000;
                    trn_phase_r <= 1'b0;
                end
            end
        end
    end

    assign train_end = go_r && func_act_r == pwo_pkg::PWO_FN_TRAIN && !done_r &&
        ((pulses_r == trn_act_r.count) && !trn_phase_r);

    // Output mux: one function owns the pin
    always_comb begin
        case (func_act_r)
            pwo_pkg::PWO_FN_COUNTER: pin_nxt = counter_out;
            pwo_pkg::PWO_FN_PWM: pin_nxt = pwm_level_r & (pwm_act_r.period != 16'h0000);
            pwo_pkg::PWO_FN_TRAIN: pin_nxt = go_r & trn_phase_r;
            default: pin_nxt = 1'b0;
        endcase
    end

    // Pin is registered so it never glitches between functions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_dc_out_pin <= 1'b0;
        end else begin
            fast_dc_out_pin <= pin_nxt;
        end
    end

    // Sticky events: train done and run entry; set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_en && pready && paddr == `PWO_ADDR_IRQ_STAT && pwdata[i]) begin
                    irq_stat_r[i] <= 1'b0;
                end
            end
            if (train_end) begin
                irq_stat_r[`PWO_IRQ_DONE_BIT] <= 1'b1;
            end
            if (run_rise) begin
                irq_stat_r[`PWO_IRQ_RUN_BIT] <= 1'b1;
            end
        end
    end

    // Level interrupt from a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // Read data registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `PWO_ADDR_PWM_PERIOD: prdata <= {16'h0000, pwm_sw_r.period};
                `PWO_ADDR_PWM_HIGH: prdata <= {16'h0000, pwm_sw_r.high};
                `PWO_ADDR_TRN_PERIOD: prdata <= {16'h0000, trn_sw_r.period};
                `PWO_ADDR_TRN_COUNT: prdata <= {16'h0000, trn_sw_r.count};
                `PWO_ADDR_CTRL: prdata <= {27'h0, quad_sw_r, func_sw_r, run_r, go_r};
                `PWO_ADDR_STATUS: prdata <= {27'h0, func_act_r, fast_dc_out_pin, run_r, done_r};
                `PWO_ADDR_IRQ_STAT: prdata <= {30'h0, irq_stat_r};
                `PWO_ADDR_IRQ_MASK: prdata <= {30'h0, irq_mask_r};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

endmodule : pwo_top

// ===== rtl/pwo_defines.svh
// Register offsets, field positions, reset values and timing counts for the fast output generator
// Function
// - Fast output pin driven by one function
// - Quadrature mode disables PWM and pulse train
// - Function configuration loaded only on stop-to-run
// - Run entry halts old function, starts new
// - PWM frequency set by period word
// - PWM duty set by high-time word
// - PWM keeps running after run-to-stop
// - PWM state retained across power loss; the RTL clears it on presetn and leaves retention to the supply domain
// - Period is (word+1) times eight base cycles
// - High-time word from duty and frequency
// - On time counts in eight-cycle units
// - Period and high-time words are unsigned 16-bit
// - Train uses period, count, go, done
// - Go bit starts train, clears done
// - After count pulses set done, clear go
// - Train frequency set by train period word
`ifndef PWO_DEFINES_SVH
`define PWO_DEFINES_SVH

`define PWO_ADDR_PWM_PERIOD 12'h000
`define PWO_ADDR_PWM_HIGH 12'h004
`define PWO_ADDR_TRN_PERIOD 12'h008
`define PWO_ADDR_TRN_COUNT 12'h00C
`define PWO_ADDR_CTRL 12'h010
`define PWO_ADDR_STATUS 12'h014
`define PWO_ADDR_IRQ_STAT 12'h018
`define PWO_ADDR_IRQ_MASK 12'h01C

`define PWO_CTRL_GO_BIT 0
`define PWO_CTRL_RUN_BIT 1
`define PWO_CTRL_FUNC_LSB 2
`define PWO_CTRL_QUAD_BIT 4

`define PWO_STAT_DONE_BIT 0
`define PWO_STAT_RUN_BIT 1
`define PWO_STAT_PIN_BIT 2
`define PWO_STAT_FUNC_LSB 3

`define PWO_IRQ_DONE_BIT 0
`define PWO_IRQ_RUN_BIT 1

`define PWO_RST_WORD 16'h0000
`define PWO_PRESCALE 4'h8
`define PWO_BASE_MHZ_X100 984

`endif

// ===== rtl/pwo_pkg.sv
// Types shared by the fast output generator
package pwo_pkg;

    typedef enum logic [1:0] {
        PWO_FN_COUNTER,
        PWO_FN_PWM,
        PWO_FN_TRAIN,
        PWO_FN_NONE
    } pwo_func_t;

    typedef struct packed {
        logic [15:0] period;
        logic [15:0] high;
    } pwo_pwm_cfg_t;

    typedef struct packed {
        logic [15:0] period;
        logic [15:0] count;
    } pwo_trn_cfg_t;

endpackage : pwo_pkg

// ===== tb/pwo_asserts.sv
// Bus, interrupt and reset assertions for the fast output generator
`timescale 1ns/1ps
`include "pwo_defines.svh"
module pwo_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic base_clk_en,
    input wire logic counter_out,
    input wire logic fast_dc_out_pin,
    input wire logic irq
);
    logic [1:0] mask_r;
    logic setup;
    assign setup = psel && !penable;
    // Shadow of the mask, so irq can be judged without internal state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= 2'h0;
        end else if (psel && penable && pready && pwrite && paddr == `PWO_ADDR_IRQ_MASK) begin
            mask_r <= pwdata[1:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
    access_ready_a: assert property (setup |=> pready) else $error("no answer in access");
    stray_ready_a: assert property (!setup |=> !pready) else $error("pready without setup");
    bad_addr_a: assert property (setup && (paddr > 12'h01C || paddr[1:0] != 2'h0) |=> pslverr)
        else $error("bad address accepted");
    good_addr_a: assert property (setup && paddr <= 12'h01C && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("good address refused");
    err_read_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    irq_masked_a: assert property ((mask_r == 2'h0) [*2] |=> !irq) else $error("irq while masked");
    reset_quiet_a: assert property ($rose(presetn) |-> !pready && !irq && !fast_dc_out_pin)
        else $error("outputs busy after reset");
    err_c: cover property (pready && pslverr);
    irq_c: cover property ($rose(irq));
    pin_c: cover property ($rose(fast_dc_out_pin));
endmodule : pwo_asserts

// ===== tb/pwo_load_model.sv
// Behavioural load on the fast output: counts pulses and times them
`timescale 1ns/1ps
module pwo_load_model (
    input wire logic pclk,
    input wire logic pin,
    output int rises,
    output int high_len,
    output int per_len
);
    int t;
    int t_rise;
    logic pin_q;
    // Times in cycles between edges; only edges are seen, as a real drive would
    initial begin
        rises = 0;
        high_len = 0;
        per_len = 0;
        t = 0;
        t_rise = 0;
        pin_q = 1'b0;
    end
    always @(posedge pclk) begin
        t <= t + 1;
        pin_q <= pin;
        if (pin && !pin_q) begin
            rises <= rises + 1;
            per_len <= t - t_rise;
            t_rise <= t;
        end
        if (!pin && pin_q) begin
            high_len <= t - t_rise;
        end
    end
endmodule : pwo_load_model

// ===== tb/tb_top.sv
// Self-checking testbench for the fast output generator
`timescale 1ns/1ps
`include "pwo_defines.svh"
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, counter_out, pslverr, pready, pin, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    int fails = 0, checked = 0, rises, hi, per, p, h, c, n;

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Base enable tied high so each tick is eight cycles and runs stay short
    pwo_top i_pwo_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .base_clk_en(1'b1), .counter_out(counter_out), .fast_dc_out_pin(pin), .irq(irq));
    pwo_load_model i_pwo_load_model (.pclk(pclk), .pin(pin), .rises(rises), .high_len(hi), .per_len(per));

    task finish_test();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test

    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    // One APB transfer, then an idle edge so the next setup never lands in the same step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 50) begin
            fails++;
            finish_test();
        end
        @(posedge pclk);
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(r & m, e);
    endtask : rd

    // Bounded waits on pulses seen by the load, or on the interrupt
    task wait_for(input int k, input logic on_irq);
        int i;
        n = rises + k;
        for (i = 0; i < 3000 && (on_irq ? irq !== 1'b1 : rises < n); i++) @(posedge pclk);
        if (i >= 3000) begin
            fails++;
            finish_test();
        end
    endtask : wait_for

    task rerun(input logic [31:0] ctl);
        wr(`PWO_ADDR_CTRL, ctl & 32'hFFFFFFFD);
        wr(`PWO_ADDR_CTRL, ctl);
    endtask : rerun

    initial begin
        {psel, penable, pwrite, paddr, pwdata, counter_out, presetn} = '0;
        void'($urandom(1254));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`PWO_ADDR_PWM_PERIOD, 32'hFFFFFFFF, 32'h0);
        rd(`PWO_ADDR_PWM_HIGH, 32'hFFFFFFFF, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk(err, 32'h1);
        chk(r, 32'h0);
        p = 2 + $urandom % 6;
        h = 1 + $urandom % (p - 1);
        wr(`PWO_ADDR_PWM_PERIOD, p);
        wr(`PWO_ADDR_PWM_HIGH, h);
        rerun(32'h6);
        wait_for(3, 1'b0);
        chk(per, (p + 1) * 8);
        chk(hi, (h + 1) * 8);
        rd(`PWO_ADDR_STATUS, 32'h18, 32'h08);
        wr(`PWO_ADDR_PWM_PERIOD, p + 1);
        wait_for(3, 1'b0);
        chk(per, (p + 1) * 8);
        wr(`PWO_ADDR_CTRL, 32'h4);
        wait_for(3, 1'b0);
        chk(per, (p + 1) * 8);
        wr(`PWO_ADDR_CTRL, 32'h6);
        wait_for(3, 1'b0);
        chk(per, (p + 2) * 8);
        wr(`PWO_ADDR_PWM_HIGH, 32'h0);
        rerun(32'h6);
        repeat (40) @(posedge pclk);
        n = rises;
        repeat (100) @(posedge pclk);
        chk(rises, n);
        chk(pin, 32'h1);
        wr(`PWO_ADDR_PWM_PERIOD, 32'h0);
        rerun(32'h6);
        repeat (20) @(posedge pclk);
        chk(pin, 32'h0);
        wr(`PWO_ADDR_PWM_PERIOD, p);
        rerun(32'h16);
        repeat (60) @(posedge pclk);
        chk(pin, 32'h0);
        rd(`PWO_ADDR_STATUS, 32'h18, 32'h18);
        rerun(32'h2);
        for (c = 0; c < 8; c++) begin
            counter_out <= 1'($urandom);
            repeat (3) @(posedge pclk);
            chk(pin, counter_out);
        end
        wr(`PWO_ADDR_IRQ_MASK, 32'h1);
        wr(`PWO_ADDR_TRN_PERIOD, 32'h1);
        c = 2 + $urandom % 3;
        wr(`PWO_ADDR_TRN_COUNT, c);
        rerun(32'hA);
        n = rises;
        wr(`PWO_ADDR_CTRL, 32'hB);
        wait_for(0, 1'b1);
        chk(rises - n, c);
        chk(hi, 16);
        rd(`PWO_ADDR_STATUS, 32'h1, 32'h1);
        rd(`PWO_ADDR_CTRL, 32'h1, 32'h0);
        wr(`PWO_ADDR_IRQ_STAT, 32'h1);
        repeat (2) @(posedge pclk);
        chk(irq, 32'h0);
        wr(`PWO_ADDR_IRQ_MASK, 32'h0);
        wr(`PWO_ADDR_CTRL, 32'hB);
        rd(`PWO_ADDR_STATUS, 32'h1, 32'h0);
        repeat (c * 32 + 40) @(posedge pclk);
        chk(irq, 32'h0);
        rd(`PWO_ADDR_IRQ_STAT, 32'h1, 32'h1);
        finish_test();
    end
endmodule : tb_top

bind pwo_top pwo_asserts i_pwo_asserts (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .base_clk_en(base_clk_en), .counter_out(counter_out), .fast_dc_out_pin(fast_dc_out_pin), .irq(irq));
